// ---- core/hrbp_pkg.sv ----
/*
  Constants and carrier types for the host register bus port.
  Assumes a single system clock at 250 MHz; imported by both design files.
*/
package hrbp_pkg;

  // ------------------------------------------------------------
  // Mode select encodings
  // ------------------------------------------------------------
  localparam logic [2:0] HRBP_MODE_ASYNC  = 3'h0;
  localparam logic [2:0] HRBP_MODE_ASYNC2 = 3'h1;
  localparam logic [2:0] HRBP_MODE_SYNC   = 3'h7;

  // ------------------------------------------------------------
  // Field positions and widths
  // ------------------------------------------------------------
  localparam int HRBP_DATA_W    = 8;
  localparam int HRBP_ADDR_W    = 11;
  localparam int HRBP_REG_ADR_W = 8;
  localparam int HRBP_CSEL_MSB  = 10;
  localparam int HRBP_CSEL_LSB  = 8;
  localparam int HRBP_CSEL_N    = 8;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int HRBP_CLK_PERIOD_NS = 4;
  localparam int HRBP_RDY_MAX_NS    = 150;
  localparam int HRBP_RDY_MAX_CYC   = HRBP_RDY_MAX_NS / HRBP_CLK_PERIOD_NS;
  localparam int HRBP_SYNC_STAGES   = 2;
  localparam logic [HRBP_DATA_W-1:0] HRBP_DATA_RST = 8'h00;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       cs_n;
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       upclk;
  } hrbp_ctl_t;

  typedef struct packed {
    logic                      wr_stb;
    logic                      rd_stb;
    logic [HRBP_REG_ADR_W-1:0] addr;
    logic [HRBP_DATA_W-1:0]    wdata;
  } hrbp_req_t;

  typedef enum logic [1:0] {
    HRBP_IDLE = 2'b00,
    HRBP_WAIT = 2'b01,
    HRBP_DONE = 2'b11,
    HRBP_HOLD = 2'b10
  } hrbp_state_t;

endpackage : hrbp_pkg

// ---- core/hrbp_sync.sv ----
/*
  Two-flop synchroniser bank for the host strobes.
  Assumes inputs may change at any time relative to mclk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module hrbp_sync
  import hrbp_pkg::*;
#(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;
  logic             init_reg;

  // ------------------------------------------------------------
  // Synchroniser; reset value is loaded after release
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // All high in reset so no false low-going strobe edge follows release
      meta_reg <= '1;
      q_reg    <= '1;
      init_reg <= 1'b0;
    end else begin
      meta_reg <= d_i;
      init_reg <= 1'b1;
      q_reg    <= init_reg ? meta_reg : rst_val_i;
    end
  end

  assign q_o = q_reg;

endmodule : hrbp_sync
`default_nettype wire

// ---- core/hrbp_port.sv ----
/*
  Host register bus port: async strobe mode and sync clocked mode.
  Assumes a register file outside that answers reg_rdata_i combinationally
  from reg_addr_o, and takes a one-cycle reg_wr_o pulse.
*/
`timescale 1ns/1ns
`default_nettype none

module hrbp_port
  import hrbp_pkg::*;
(
  // Clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      resetn_i,
  // Host pins
  input  wire logic [2:0]                iface_mode_sel_i,
  input  wire logic [HRBP_ADDR_W-1:0]    addr_i,
  input  wire logic                      cs_n_i,
  input  wire logic                      addr_latch_pin_i,
  input  wire logic                      rd_n_i,
  input  wire logic                      wr_n_i,
  input  wire logic                      upclk_i,
  input  wire logic [HRBP_DATA_W-1:0]    data_i,
  output logic      [HRBP_DATA_W-1:0]    data_o,
  output logic                           data_oe_o,
  output logic                           cycle_done_n_o,
  output logic      [HRBP_CSEL_N-1:0]    companion_cs_n_o,
  // Register file side
  output logic      [HRBP_REG_ADR_W-1:0] reg_addr_o,
  output logic      [HRBP_DATA_W-1:0]    reg_wdata_o,
  output logic                           reg_wr_o,
  output logic                           reg_rd_o,
  input  wire logic [HRBP_DATA_W-1:0]    reg_rdata_i,
  output logic                           mode_err_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [HRBP_CSEL_N-1:0] csel_decode(input logic [2:0] sel);
    logic [HRBP_CSEL_N-1:0] v;
    v = '1;
    v[sel] = 1'b0;
    return v;
  endfunction : csel_decode

  hrbp_ctl_t        ctl_raw;
  hrbp_ctl_t        ctl_s;
  hrbp_ctl_t        ctl_d_reg;
  hrbp_ctl_t        ctl_rst;
  hrbp_req_t        req;
  hrbp_state_t      state_reg;
  hrbp_state_t      state_next;
  logic             sync_mode;
  logic             mode_ok;
  logic             clk_rise;
  logic             strobe_on;
  logic             start_rd;
  logic             start_wr;
  logic [HRBP_REG_ADR_W-1:0] addr_lat_reg;
  logic [HRBP_REG_ADR_W-1:0] addr_eff;
  logic             rd_cyc_reg;
  logic [HRBP_DATA_W-1:0]    wdata_reg;
  logic             dir_rd;

  // ------------------------------------------------------------
  // Strobe synchronisation
  // ------------------------------------------------------------
  assign ctl_raw = '{cs_n: cs_n_i, ale: addr_latch_pin_i, rd_n: rd_n_i,
                     wr_n: wr_n_i, upclk: upclk_i};
  assign ctl_rst = '{cs_n: 1'b1, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, upclk: 1'b0};

  hrbp_sync #(.WIDTH($bits(hrbp_ctl_t))) u_sync (
    .mclk_i    (mclk_i),
    .resetn_i  (resetn_i),
    .d_i       (ctl_raw),
    .rst_val_i (ctl_rst),
    .q_o       (ctl_s)
  );

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_d_reg <= '{cs_n: 1'b1, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, upclk: 1'b0};
    end else begin
      ctl_d_reg <= ctl_s;
    end
  end

  // ------------------------------------------------------------
  // Mode decode and edge detection
  // ------------------------------------------------------------
  assign sync_mode = (iface_mode_sel_i == HRBP_MODE_SYNC);
  assign mode_ok   = (iface_mode_sel_i == HRBP_MODE_ASYNC) ||
                     (iface_mode_sel_i == HRBP_MODE_ASYNC2) || sync_mode;
  assign clk_rise  = !ctl_d_reg.upclk && ctl_s.upclk;
  // In sync mode the write input carries direction (high is read), read input the data strobe
  assign dir_rd    = ctl_s.wr_n;
  assign strobe_on = !ctl_s.cs_n && (sync_mode ? !ctl_s.rd_n : (!ctl_s.rd_n || !ctl_s.wr_n));

  always_comb begin
    start_rd = 1'b0;
    start_wr = 1'b0;
    if (mode_ok && !ctl_s.cs_n) begin
      if (sync_mode) begin
        if (clk_rise && !ctl_s.rd_n) begin
          start_rd = dir_rd;
          start_wr = !dir_rd;
        end
      end else begin
        start_rd = ctl_d_reg.rd_n && !ctl_s.rd_n;
        start_wr = ctl_d_reg.wr_n && !ctl_s.wr_n;
      end
    end
  end

  // ------------------------------------------------------------
  // Address latch, transparent while strobe high
  // ------------------------------------------------------------
  // Pin level is used unsynchronised so the address is held from the fall itself
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_lat_reg <= '0;
    end else if (addr_latch_pin_i) begin
      addr_lat_reg <= addr_i[HRBP_REG_ADR_W-1:0];
    end
  end

  assign addr_eff = addr_latch_pin_i ? addr_i[HRBP_REG_ADR_W-1:0] : addr_lat_reg;

  // ------------------------------------------------------------
  // Cycle state machine
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HRBP_IDLE: begin
        if (start_rd || start_wr) begin
          state_next = HRBP_WAIT;
        end
      end
      HRBP_WAIT: begin
        state_next = HRBP_DONE;
      end
      HRBP_DONE: begin
        if (!strobe_on) begin
          state_next = HRBP_HOLD;
        end
      end
      HRBP_HOLD: begin
        state_next = HRBP_IDLE;
      end
      default: begin
        state_next = HRBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= HRBP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_cyc_reg <= 1'b0;
      wdata_reg  <= HRBP_DATA_RST;
    end else if (state_reg == HRBP_IDLE && (start_rd || start_wr)) begin
      rd_cyc_reg <= start_rd;
      wdata_reg  <= data_i;
    end
  end

  // ------------------------------------------------------------
  // Register file access, one strobe per cycle
  // ------------------------------------------------------------
  assign req = '{wr_stb: state_reg == HRBP_WAIT && !rd_cyc_reg,
                 rd_stb: state_reg == HRBP_WAIT && rd_cyc_reg,
                 addr: addr_eff, wdata: wdata_reg};

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_addr_o  <= '0;
      reg_wdata_o <= HRBP_DATA_RST;
      reg_wr_o    <= 1'b0;
      reg_rd_o    <= 1'b0;
    end else begin
      if (state_reg == HRBP_IDLE) begin
        reg_addr_o <= req.addr;
      end
      reg_wdata_o <= req.wdata;
      reg_wr_o    <= req.wr_stb;
      reg_rd_o    <= req.rd_stb;
    end
  end

  // ------------------------------------------------------------
  // Host facing outputs
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_o         <= HRBP_DATA_RST;
      data_oe_o      <= 1'b0;
      cycle_done_n_o <= 1'b1;
    end else begin
      if (state_next == HRBP_WAIT && start_rd) begin
        data_oe_o <= 1'b1;
      end else if (state_next == HRBP_IDLE) begin
        data_oe_o <= 1'b0;
      end
      if (state_reg == HRBP_WAIT && rd_cyc_reg) begin
        data_o <= reg_rdata_i;
      end
      // Completion on the same edge that data_o is loaded; well within 150 ns
      cycle_done_n_o <= !(state_next == HRBP_DONE);
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      companion_cs_n_o <= '1;
      mode_err_o       <= 1'b0;
    end else begin
      companion_cs_n_o <= ctl_s.cs_n ? '1
                          : csel_decode(addr_i[HRBP_CSEL_MSB:HRBP_CSEL_LSB]);
      mode_err_o       <= !mode_ok;
    end
  end

endmodule : hrbp_port
`default_nettype wire

// ---- tb/hrbp_port_checker.sv ----
/*
  Pin-level assertions for the host register bus port.
  Assumes it is bound to hrbp_port and sees only that module's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module hrbp_port_checker
  import hrbp_pkg::*;
(
  // Clock and reset
  input wire logic                   mclk_i,
  input wire logic                   resetn_i,
  // Watched pins
  input wire logic [2:0]             iface_mode_sel_i,
  input wire logic [HRBP_ADDR_W-1:0] addr_i,
  input wire logic                   cs_n_i,
  input wire logic                   rd_n_i,
  input wire logic                   wr_n_i,
  input wire logic                   data_oe_o,
  input wire logic                   cycle_done_n_o,
  input wire logic [HRBP_CSEL_N-1:0] companion_cs_n_o,
  input wire logic                   reg_wr_o,
  input wire logic                   reg_rd_o,
  input wire logic                   mode_err_o
);
  localparam int RDY_MAX = 37;
  logic async_sel;
  assign async_sel = !cs_n_i && (iface_mode_sel_i inside {HRBP_MODE_ASYNC, HRBP_MODE_ASYNC2});
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // ------------------------------------------------------------
  // Handshake, companion select and mode decode
  // ------------------------------------------------------------
  sequence s_done;
    ##[1:RDY_MAX] !cycle_done_n_o;
  endsequence
  sequence s_freed;
    ##[1:8] (cycle_done_n_o && !data_oe_o);
  endsequence
  property p_rd_ready; $fell(rd_n_i) && async_sel |-> s_done; endproperty
  property p_wr_ready; $fell(wr_n_i) && async_sel |-> s_done; endproperty
  property p_rd_drive; !rd_n_i && !cycle_done_n_o && async_sel |-> data_oe_o; endproperty
  property p_wr_quiet; reg_wr_o |-> !data_oe_o; endproperty
  property p_wr_ack; reg_wr_o |-> ##[0:2] !cycle_done_n_o; endproperty
  property p_one_wr; reg_wr_o |=> !reg_wr_o; endproperty
  property p_release; $rose(rd_n_i) |-> s_freed; endproperty
  property p_cs_idle; cs_n_i [*6] |-> !reg_wr_o && cycle_done_n_o && (&companion_cs_n_o); endproperty
  property p_comp; (!cs_n_i && $stable(addr_i)) [*4] |-> companion_cs_n_o == ~(8'h01 << addr_i[10:8]); endproperty
  property p_rd_strobe; reg_rd_o |-> (data_oe_o && !reg_wr_o) ##1 !reg_rd_o; endproperty
  property p_mode;
    $stable(iface_mode_sel_i) [*3] |-> mode_err_o == !(iface_mode_sel_i inside {3'h0, 3'h1, 3'h7});
  endproperty
  a_rd_ready: assert property (p_rd_ready) else $error("ready late after read strobe");
  a_wr_ready: assert property (p_wr_ready) else $error("ready late after write strobe");
  a_rd_drive: assert property (p_rd_drive) else $error("bus not driven on read");
  a_wr_quiet: assert property (p_wr_quiet) else $error("bus driven on write");
  a_wr_ack: assert property (p_wr_ack) else $error("write without completion");
  a_one_wr: assert property (p_one_wr) else $error("write pulse too long");
  a_release: assert property (p_release) else $error("completion not released");
  a_cs_idle: assert property (p_cs_idle) else $error("activity while deselected");
  a_comp: assert property (p_comp) else $error("companion select wrong");
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  a_rd_strobe: assert property (p_rd_strobe) else $error("register read pulse wrong");
endmodule : hrbp_port_checker
bind hrbp_port hrbp_port_checker u_chk (.*);
`default_nettype wire

// ---- tb/hrbp_regfile_model.sv ----
/*
  Register file standing behind the host port.
  Answers reads combinationally and takes one-cycle write pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module hrbp_regfile_model
  import hrbp_pkg::*;
(
  // Clock
  input  wire logic                      mclk_i,
  // Access
  input  wire logic [HRBP_REG_ADR_W-1:0] reg_addr_i,
  input  wire logic [HRBP_DATA_W-1:0]    reg_wdata_i,
  input  wire logic                      reg_wr_i,
  output logic      [HRBP_DATA_W-1:0]    reg_rdata_o
);
  logic [HRBP_DATA_W-1:0] mem [256];
  // Unwritten places read as the inverted address
  initial for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
  assign reg_rdata_o = mem[reg_addr_i];
  always @(posedge mclk_i) begin
    if (reg_wr_i) begin
      mem[reg_addr_i] <= reg_wdata_i;
    end
  end
endmodule : hrbp_regfile_model
`default_nettype wire

// ---- tb/hrbp_port_tb.sv ----
/*
  Self-checking bench for the host register bus port.
  Assumes the register file model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module hrbp_port_tb;
  import hrbp_pkg::*;
  logic        mclk = 0, resetn = 0, cs_n = 1, ale = 0, rd_n = 1, wr_n = 1, upclk = 0, hold_ale = 0;
  logic [2:0]  mode = HRBP_MODE_ASYNC;
  logic [10:0] addr = 11'h000;
  logic [7:0]  din = 8'h00, bus, dout, comp, raddr, rwdata, rrdata;
  logic        oe, done_n, rwr, merr;
  int          failures = 0, total_checks = 0;
  assign bus = oe ? dout : din;
  hrbp_port uut (.mclk_i(mclk), .resetn_i(resetn), .iface_mode_sel_i(mode), .addr_i(addr), .cs_n_i(cs_n),
    .addr_latch_pin_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n), .upclk_i(upclk), .data_i(bus), .data_o(dout),
    .data_oe_o(oe), .cycle_done_n_o(done_n), .companion_cs_n_o(comp), .reg_addr_o(raddr),
    .reg_wdata_o(rwdata), .reg_wr_o(rwr), .reg_rd_o(), .reg_rdata_i(rrdata), .mode_err_o(merr));
  hrbp_regfile_model u_regs (.mclk_i(mclk), .reg_addr_i(raddr), .reg_wdata_i(rwdata), .reg_wr_i(rwr),
    .reg_rdata_o(rrdata));
  initial forever #2 mclk = ~mclk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic restart(input logic [2:0] m);
    @(negedge mclk);
    resetn = 0;
    mode = m;
    repeat (2) @(negedge mclk);
    resetn = 1;
    repeat (4) @(negedge mclk);
  endtask : restart
  // One host cycle; in sync mode wr_n is the direction, high meaning read
  task automatic access(input logic rd, input logic [10:0] a, input logic [7:0] wd, output logic [7:0] rdat);
    int n;
    @(negedge mclk);
    addr = a;
    cs_n = 0;
    ale = 1;
    @(negedge mclk);
    if (!hold_ale) begin
      ale = 0;
      @(negedge mclk);
      addr = ~a;
    end
    din = wd;
    rd_n = (mode == HRBP_MODE_SYNC) ? 1'b0 : !rd;
    wr_n = rd;
    n = 0;
    while (done_n !== 1'b0 && n < 60) begin
      @(negedge mclk);
      n++;
      if (n % 3 == 0) upclk = ~upclk;
    end
    chk(8'(n <= 37), 8'h01);
    chk({7'h0, oe}, {7'h0, rd});
    rdat = dout;
    rd_n = 1;
    wr_n = 1;
    repeat (8) @(negedge mclk);
    chk({6'h0, done_n, oe}, 8'h02);
    cs_n = 1;
    din = ~wd;
    ale = 0;
  endtask : access
  task automatic t_rw(input logic [2:0] m, input logic h, input logic [7:0] r);
    logic [7:0] d;
    restart(m);
    hold_ale = h;
    access(0, {3'h5, r}, 8'h5A ^ r, d);
    access(1, {3'h2, r}, 8'h00, d);
    chk(d, 8'h5A ^ r);
    access(1, {3'h0, r + 8'h01}, 8'h00, d);
    chk(d, ~(r + 8'h01));
    hold_ale = 0;
  endtask : t_rw
  task automatic t_cs_high(input logic [7:0] r);
    logic [7:0] d;
    addr = {3'h0, r};
    din = 8'h00;
    rd_n = 0;
    wr_n = 0;
    repeat (20) begin
      @(negedge mclk);
      upclk = ~upclk;
      chk({6'h0, done_n, oe}, 8'h02);
    end
    rd_n = 1;
    wr_n = 1;
    repeat (8) @(negedge mclk);
    access(1, {3'h0, r}, 8'h00, d);
    chk(d, 8'h5A ^ r);
  endtask : t_cs_high
  task automatic t_comp;
    cs_n = 0;
    for (int k = 0; k < 8; k++) begin
      addr = {k[2:0], 8'h00};
      repeat (4) @(negedge mclk);
      chk(comp, ~(8'h01 << k));
    end
    cs_n = 1;
    repeat (6) @(negedge mclk);
    chk(comp, 8'hFF);
  endtask : t_comp
  task automatic t_mode_err;
    for (int m = 0; m < 8; m++) begin
      mode = m[2:0];
      repeat (4) @(negedge mclk);
      chk({7'h0, merr}, 8'(!(m inside {0, 1, 7})));
    end
  endtask : t_mode_err
  task automatic test_done;
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    #40000;
    failures++;
    test_done;
  end
  initial begin
    t_rw(HRBP_MODE_ASYNC, 0, 8'h12);
    t_rw(HRBP_MODE_ASYNC2, 0, 8'h34);
    t_rw(HRBP_MODE_ASYNC, 1, 8'hFE);
    t_cs_high(8'hFE);
    t_rw(HRBP_MODE_SYNC, 0, 8'hA3);
    t_cs_high(8'hA3);
    t_comp;
    t_mode_err;
    test_done;
  end
endmodule : hrbp_port_tb
`default_nettype wire
